// ===== core/hdlc_link_map.sv
// link map, receive control and received code register bank behind axi4-lite
//
// How it works
// - interrupt when code irq enable and flag set
// - flag set on code update, write-one clears
// - declared message loads code field, resets ones
// - transmit link enables gate each transmitter
// - receive link enables gate each receiver
// - link one enables need esf or dm
// - transmit insert only in selected even/odd frames
// - transmit timeslot field selects channel 1..24
// - receive extract only in selected even/odd frames
// - receive timeslot field selects channel 1..24
// - both frame selects zero disables slot map
// - transmit mask bit picks inserted channel bits
// - receive mask bit picks extracted channel bits
// - mask bit 7 is first channel bit
// - status unit filter drops repeated lssu
// - fill unit filter drops repeated fisu
// - address mode field selects address checking
// - protocol select: hdlc at 0, ss7 at 1
// - rising reset bit pulses receiver reset
module hdlc_link_map (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // axi4-lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [hdlc_map_pkg::ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   // axi4-lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [hdlc_map_pkg::DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [hdlc_map_pkg::ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   // axi4-lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [hdlc_map_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   // received code events, one per framer
   input wire logic [hdlc_map_pkg::NUM_FRAMERS-1:0] code_declared,
   input wire logic [hdlc_map_pkg::NUM_FRAMERS*hdlc_map_pkg::CODE_W-1:0] code_value,
   // framing format, one per framer: high in esf or t1 dm
   input wire logic [hdlc_map_pkg::NUM_FRAMERS-1:0] esf_or_dm,
   // stream position, one per framer
   input wire logic [hdlc_map_pkg::NUM_FRAMERS-1:0] frame_odd,
   input wire logic [hdlc_map_pkg::NUM_FRAMERS*hdlc_map_pkg::TS_W-1:0] chan_index,
   input wire logic [hdlc_map_pkg::NUM_FRAMERS*hdlc_map_pkg::BITSEL_W-1:0] bit_pos,
   // link controls, framer*3 + (link-1)
   output logic [hdlc_map_pkg::NUM_FRAMERS*hdlc_map_pkg::NUM_LINKS-1:0] tx_link_on,
   output logic [hdlc_map_pkg::NUM_FRAMERS*hdlc_map_pkg::NUM_LINKS-1:0] rx_link_on,
   output logic [hdlc_map_pkg::NUM_FRAMERS*hdlc_map_pkg::NUM_LINKS-1:0] status_unit_filter,
   output logic [hdlc_map_pkg::NUM_FRAMERS*hdlc_map_pkg::NUM_LINKS-1:0] fill_unit_filter,
   output logic [hdlc_map_pkg::NUM_FRAMERS*hdlc_map_pkg::NUM_LINKS*2-1:0] address_match_mode,
   output logic [hdlc_map_pkg::NUM_FRAMERS*hdlc_map_pkg::NUM_LINKS-1:0] rx_protocol_select,
   output logic [hdlc_map_pkg::NUM_FRAMERS*hdlc_map_pkg::NUM_LINKS-1:0] rx_link_reset,
   // slot strobes for links 2 and 3, framer*2 + (link-2)
   output logic [hdlc_map_pkg::NUM_FRAMERS*hdlc_map_pkg::NUM_MAPPED-1:0] tx_insert,
   output logic [hdlc_map_pkg::NUM_FRAMERS*hdlc_map_pkg::NUM_MAPPED-1:0] rx_extract,
   // message validation mode, one per framer
   output logic [hdlc_map_pkg::NUM_FRAMERS-1:0] code_avc_mode,
   // interrupt, active high
   output logic irq
);
   import hdlc_map_pkg::*;

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------

   // index to {hit, slot}
   function automatic logic [SLOT_W:0] slot_of(input logic [7:0] ofs);
      logic [SLOT_W:0] res;
      res = {1'b1, SLOT_CODE_CTRL};
      case (ofs)
         OFS_CODE_CTRL: res = {1'b1, SLOT_CODE_CTRL};
         OFS_CODE_FLAG: res = {1'b1, SLOT_CODE_FLAG};
         OFS_CODE_VALUE: res = {1'b1, SLOT_CODE_VALUE};
         OFS_TX_EN: res = {1'b1, SLOT_TX_EN};
         OFS_TX2_ASSIGN: res = {1'b1, SLOT_TX_ASSIGN};
         OFS_TX3_ASSIGN: res = {1'b1, SLOT_TX_ASSIGN + 4'h1};
         OFS_TX2_MASK: res = {1'b1, SLOT_TX_MASK};
         OFS_TX3_MASK: res = {1'b1, SLOT_TX_MASK + 4'h1};
         OFS_RX_EN: res = {1'b1, SLOT_RX_EN};
         OFS_RX2_ASSIGN: res = {1'b1, SLOT_RX_ASSIGN};
         OFS_RX3_ASSIGN: res = {1'b1, SLOT_RX_ASSIGN + 4'h1};
         OFS_RX2_MASK: res = {1'b1, SLOT_RX_MASK};
         OFS_RX3_MASK: res = {1'b1, SLOT_RX_MASK + 4'h1};
         OFS_RX1_CTRL: res = {1'b1, SLOT_RX_CTRL};
         OFS_RX2_CTRL: res = {1'b1, SLOT_RX_CTRL + 4'h1};
         OFS_RX3_CTRL: res = {1'b1, SLOT_RX_CTRL + 4'h2};
         default: res = {1'b0, SLOT_CODE_CTRL};
      endcase
      return res;
   endfunction

   // writable bits of a slot
   function automatic logic [7:0] wmask_of(input logic [SLOT_W-1:0] s);
      logic [7:0] m;
      m = MASK_FULL;
      if (s == SLOT_CODE_CTRL) begin
         m = MASK_CODE_CTRL;
      end else if (s == SLOT_TX_EN || s == SLOT_RX_EN) begin
         m = MASK_EN;
      end else if (s == SLOT_TX_ASSIGN || s == SLOT_TX_ASSIGN + 4'h1 ||
                   s == SLOT_RX_ASSIGN || s == SLOT_RX_ASSIGN + 4'h1) begin
         m = MASK_ASSIGN;
      end else if (s >= SLOT_RX_CTRL) begin
         m = MASK_RX_CTRL;
      end
      return m;
   endfunction

   // slot map match: frame select, channel and mask bit
   function automatic logic slot_hit(input logic [7:0] asg, input logic [7:0] msk,
                                     input logic odd, input logic [TS_W-1:0] ch,
                                     input logic [BITSEL_W-1:0] bp);
      logic frame_ok;
      frame_ok = odd ? asg[ODD_BIT] : asg[EVEN_BIT];
      // channel 1 sits at code 0; codes past 23 never meet a real channel
      return frame_ok && (asg[TS_LSB +: TS_W] == ch) && msk[bp];
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [7:0] bank_ff [NUM_FRAMERS][NUM_SLOTS];  // register copies per framer
   logic [7:0] nxt_bank [NUM_FRAMERS][NUM_SLOTS];
   logic aw_held_ff, nxt_aw_held;  // write address taken
   logic w_held_ff, nxt_w_held;  // write data taken
   logic [ADDR_W-1:0] waddr_ff, nxt_waddr;
   logic [7:0] wbyte_ff, nxt_wbyte;  // low lane only; upper lanes unused
   logic wlane_ff, nxt_wlane;  // low lane strobe
   logic awready_ff, nxt_awready;
   logic wready_ff, nxt_wready;
   logic bvalid_ff, nxt_bvalid;
   logic [1:0] bresp_ff, nxt_bresp;
   logic arready_ff, nxt_arready;
   logic rvalid_ff, nxt_rvalid;
   logic [DATA_W-1:0] rdata_ff, nxt_rdata;
   logic [1:0] rresp_ff, nxt_rresp;
   logic irq_ff, nxt_irq;
   logic [NUM_FRAMERS*NUM_LINKS-1:0] tx_on_ff, nxt_tx_on;
   logic [NUM_FRAMERS*NUM_LINKS-1:0] rx_on_ff, nxt_rx_on;
   logic [NUM_FRAMERS*NUM_LINKS-1:0] rx_rst_ff, nxt_rx_rst;
   logic [NUM_FRAMERS*NUM_MAPPED-1:0] tx_ins_ff, nxt_tx_ins;
   logic [NUM_FRAMERS*NUM_MAPPED-1:0] rx_ext_ff, nxt_rx_ext;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------

   // bus handshakes, register writes, events and derived strobes
   always_comb begin
      logic [SLOT_W:0] wdec;
      logic [SLOT_W:0] rdec;
      logic [1:0] wfr;
      logic [1:0] rfr;
      logic [7:0] cv;
      wdec = slot_of(waddr_ff[INDEX_LSB +: 8]);
      rdec = slot_of(araddr[INDEX_LSB +: 8]);
      wfr = waddr_ff[FRAMER_LSB +: 2];
      rfr = araddr[FRAMER_LSB +: 2];
      cv = RST_ZERO;
      nxt_bank = bank_ff;
      nxt_aw_held = aw_held_ff;
      nxt_w_held = w_held_ff;
      nxt_waddr = waddr_ff;
      nxt_wbyte = wbyte_ff;
      nxt_wlane = wlane_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      nxt_rvalid = rvalid_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      // take address and data in either order
      if (awvalid && awready_ff) begin
         nxt_aw_held = 1'b1;
         nxt_waddr = awaddr;
      end
      if (wvalid && wready_ff) begin
         nxt_w_held = 1'b1;
         nxt_wbyte = wdata[7:0];
         nxt_wlane = wstrb[0];
      end
      // response retires
      if (bvalid_ff && bready) begin
         nxt_bvalid = 1'b0;
      end
      // both halves held: perform the write
      if (aw_held_ff && w_held_ff && !bvalid_ff) begin
         nxt_aw_held = 1'b0;
         nxt_w_held = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp = wdec[SLOT_W] ? RESP_OKAY : RESP_SLVERR;
         if (wdec[SLOT_W] && wlane_ff) begin
            if (wdec[SLOT_W-1:0] == SLOT_CODE_FLAG) begin
               // write one clears the update flag
               if (wbyte_ff[FLAG_BIT]) begin
                  nxt_bank[wfr][SLOT_CODE_FLAG][FLAG_BIT] = 1'b0;
               end
            end else if (wdec[SLOT_W-1:0] != SLOT_CODE_VALUE) begin
               // reserved bits stay zero; code field is read only
               nxt_bank[wfr][wdec[SLOT_W-1:0]] = wbyte_ff & wmask_of(wdec[SLOT_W-1:0]);
            end
         end
      end
      // declared message loads the field, set wins over clear
      for (int f = 0; f < NUM_FRAMERS; f++) begin
         if (code_declared[f]) begin
            nxt_bank[f][SLOT_CODE_VALUE] = {2'b00, code_value[f*CODE_W +: CODE_W]};
            nxt_bank[f][SLOT_CODE_FLAG][FLAG_BIT] = 1'b1;
         end
      end
      // read: answer one cycle after the address is taken
      if (rvalid_ff && rready) begin
         nxt_rvalid = 1'b0;
      end
      if (arvalid && arready_ff) begin
         nxt_rvalid = 1'b1;
         if (rdec[SLOT_W]) begin
            cv = bank_ff[rfr][rdec[SLOT_W-1:0]];
            nxt_rresp = RESP_OKAY;
         end else begin
            nxt_rresp = RESP_SLVERR;
         end
         nxt_rdata = {24'h000000, cv};
      end
      nxt_awready = !nxt_aw_held && !nxt_bvalid;
      nxt_wready = !nxt_w_held && !nxt_bvalid;
      nxt_arready = !nxt_rvalid;
      // interrupt follows enable and flag of any framer
      nxt_irq = 1'b0;
      for (int f = 0; f < NUM_FRAMERS; f++) begin
         nxt_irq = nxt_irq | (nxt_bank[f][SLOT_CODE_CTRL][IRQ_EN_BIT] &
                              nxt_bank[f][SLOT_CODE_FLAG][FLAG_BIT]);
      end
      // per link enables and receiver reset pulse
      for (int f = 0; f < NUM_FRAMERS; f++) begin
         for (int l = 0; l < NUM_LINKS; l++) begin
            nxt_tx_on[f*NUM_LINKS+l] = bank_ff[f][SLOT_TX_EN][l] &
                                       ((l != 0) | esf_or_dm[f]);
            nxt_rx_on[f*NUM_LINKS+l] = bank_ff[f][SLOT_RX_EN][l] &
                                       ((l != 0) | esf_or_dm[f]);
            nxt_rx_rst[f*NUM_LINKS+l] = nxt_bank[f][SLOT_RX_CTRL+l][RST_BIT] &
                                        ~bank_ff[f][SLOT_RX_CTRL+l][RST_BIT];
         end
         // slot strobes for links 2 and 3 only while their link runs
         for (int m = 0; m < NUM_MAPPED; m++) begin
            nxt_tx_ins[f*NUM_MAPPED+m] = bank_ff[f][SLOT_TX_EN][m+1] &
               slot_hit(bank_ff[f][SLOT_TX_ASSIGN+m], bank_ff[f][SLOT_TX_MASK+m],
                        frame_odd[f], chan_index[f*TS_W +: TS_W],
                        bit_pos[f*BITSEL_W +: BITSEL_W]);
            nxt_rx_ext[f*NUM_MAPPED+m] = bank_ff[f][SLOT_RX_EN][m+1] &
               slot_hit(bank_ff[f][SLOT_RX_ASSIGN+m], bank_ff[f][SLOT_RX_MASK+m],
                        frame_odd[f], chan_index[f*TS_W +: TS_W],
                        bit_pos[f*BITSEL_W +: BITSEL_W]);
         end
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------

   // all state, synchronous reset
   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int f = 0; f < NUM_FRAMERS; f++) begin
            for (int s = 0; s < NUM_SLOTS; s++) begin
               bank_ff[f][s] <= RST_ZERO;
            end
            bank_ff[f][SLOT_CODE_VALUE] <= RST_CODE_VALUE;
         end
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         waddr_ff <= '0;
         wbyte_ff <= 8'h00;
         wlane_ff <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= RESP_OKAY;
         irq_ff <= 1'b0;
         tx_on_ff <= '0;
         rx_on_ff <= '0;
         rx_rst_ff <= '0;
         tx_ins_ff <= '0;
         rx_ext_ff <= '0;
      end else begin
         bank_ff <= nxt_bank;
         aw_held_ff <= nxt_aw_held;
         w_held_ff <= nxt_w_held;
         waddr_ff <= nxt_waddr;
         wbyte_ff <= nxt_wbyte;
         wlane_ff <= nxt_wlane;
         awready_ff <= nxt_awready;
         wready_ff <= nxt_wready;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         arready_ff <= nxt_arready;
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
         irq_ff <= nxt_irq;
         tx_on_ff <= nxt_tx_on;
         rx_on_ff <= nxt_rx_on;
         rx_rst_ff <= nxt_rx_rst;
         tx_ins_ff <= nxt_tx_ins;
         rx_ext_ff <= nxt_rx_ext;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign awready = awready_ff;
   assign wready = wready_ff;
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;
   assign arready = arready_ff;
   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign rresp = rresp_ff;
   assign irq = irq_ff;
   assign tx_link_on = tx_on_ff;
   assign rx_link_on = rx_on_ff;
   assign rx_link_reset = rx_rst_ff;
   assign tx_insert = tx_ins_ff;
   assign rx_extract = rx_ext_ff;

   // receiver control fields straight from the register copies
   for (genvar f = 0; f < NUM_FRAMERS; f++) begin : g_fr
      assign code_avc_mode[f] = bank_ff[f][SLOT_CODE_CTRL][AVC_BIT];
      for (genvar l = 0; l < NUM_LINKS; l++) begin : g_ln
         assign status_unit_filter[f*NUM_LINKS+l] =
            bank_ff[f][SLOT_RX_CTRL+l][LSSU_BIT];
         assign fill_unit_filter[f*NUM_LINKS+l] =
            bank_ff[f][SLOT_RX_CTRL+l][FISU_BIT];
         assign address_match_mode[(f*NUM_LINKS+l)*2 +: 2] =
            bank_ff[f][SLOT_RX_CTRL+l][ADRM_LSB +: 2];
         assign rx_protocol_select[f*NUM_LINKS+l] =
            bank_ff[f][SLOT_RX_CTRL+l][PROTO_BIT];
      end
   end

endmodule

// ===== core/hdlc_map_pkg.sv
// constants for the link map and received code register bank
package hdlc_map_pkg;

   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int unsigned NUM_FRAMERS = 4;  // independent register copies
   localparam int unsigned NUM_LINKS = 3;  // links per direction
   localparam int unsigned NUM_MAPPED = 2;  // links 2 and 3 carry a slot map
   localparam int unsigned ADDR_W = 12;  // byte address width
   localparam int unsigned DATA_W = 32;  // bus data width
   localparam int unsigned REG_W = 8;  // register width
   localparam int unsigned CODE_W = 6;  // received code width
   localparam int unsigned TS_W = 5;  // timeslot field width
   localparam int unsigned BITSEL_W = 3;  // bit position width
   localparam int unsigned SLOT_W = 4;  // local register slot index width
   localparam int unsigned NUM_SLOTS = 16;  // registers per framer
   localparam int unsigned FRAMER_LSB = 10;  // byte address of framer: index 0x100 * 4
   localparam int unsigned INDEX_LSB = 2;  // register index sits above byte lanes

   // ------------------------------------------------------------
   // register indices (byte address = 4 * index)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CODE_CTRL = 8'h81;
   localparam logic [7:0] OFS_CODE_FLAG = 8'h82;
   localparam logic [7:0] OFS_CODE_VALUE = 8'h83;
   localparam logic [7:0] OFS_TX_EN = 8'h84;
   localparam logic [7:0] OFS_TX2_ASSIGN = 8'h86;
   localparam logic [7:0] OFS_TX3_ASSIGN = 8'h87;
   localparam logic [7:0] OFS_TX2_MASK = 8'h89;
   localparam logic [7:0] OFS_TX3_MASK = 8'h8a;
   localparam logic [7:0] OFS_RX_EN = 8'h8b;
   localparam logic [7:0] OFS_RX2_ASSIGN = 8'h8d;
   localparam logic [7:0] OFS_RX3_ASSIGN = 8'h8e;
   localparam logic [7:0] OFS_RX2_MASK = 8'h90;
   localparam logic [7:0] OFS_RX3_MASK = 8'h91;
   localparam logic [7:0] OFS_RX1_CTRL = 8'h92;
   localparam logic [7:0] OFS_RX2_CTRL = 8'h93;
   localparam logic [7:0] OFS_RX3_CTRL = 8'h94;

   // ------------------------------------------------------------
   // local storage slots
   // ------------------------------------------------------------
   localparam logic [3:0] SLOT_CODE_CTRL = 4'h0;
   localparam logic [3:0] SLOT_CODE_FLAG = 4'h1;
   localparam logic [3:0] SLOT_CODE_VALUE = 4'h2;
   localparam logic [3:0] SLOT_TX_EN = 4'h3;
   localparam logic [3:0] SLOT_TX_ASSIGN = 4'h4;  // links 2,3 at +0,+1
   localparam logic [3:0] SLOT_TX_MASK = 4'h6;  // links 2,3 at +0,+1
   localparam logic [3:0] SLOT_RX_EN = 4'h8;
   localparam logic [3:0] SLOT_RX_ASSIGN = 4'h9;  // links 2,3 at +0,+1
   localparam logic [3:0] SLOT_RX_MASK = 4'hb;  // links 2,3 at +0,+1
   localparam logic [3:0] SLOT_RX_CTRL = 4'hd;  // links 1..3 at +0..+2

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int unsigned IRQ_EN_BIT = 0;  // code_irq_enable
   localparam int unsigned AVC_BIT = 1;  // message validation criteria
   localparam int unsigned FLAG_BIT = 0;  // code_update_flag
   localparam int unsigned EVEN_BIT = 6;
   localparam int unsigned ODD_BIT = 5;
   localparam int unsigned TS_LSB = 0;
   localparam int unsigned RST_BIT = 0;  // rx_link_reset
   localparam int unsigned PROTO_BIT = 1;  // rx_protocol_select
   localparam int unsigned ADRM_LSB = 2;  // address_match_mode
   localparam int unsigned FISU_BIT = 4;  // fill_unit_filter
   localparam int unsigned LSSU_BIT = 5;  // status_unit_filter

   // ------------------------------------------------------------
   // writable masks and reset values
   // ------------------------------------------------------------
   localparam logic [7:0] MASK_CODE_CTRL = 8'h03;
   localparam logic [7:0] MASK_EN = 8'h07;
   localparam logic [7:0] MASK_ASSIGN = 8'h7f;
   localparam logic [7:0] MASK_FULL = 8'hff;
   localparam logic [7:0] MASK_RX_CTRL = 8'h3f;
   localparam logic [7:0] RST_CODE_VALUE = 8'h3f;
   localparam logic [7:0] RST_ZERO = 8'h00;

   // ------------------------------------------------------------
   // bus responses
   // ------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ===== tb/hdlc_link_map_props.sv
// bus handshake and receiver reset assertions for the link map bank
module hdlc_link_map_props (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // bus handshakes
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [hdlc_map_pkg::DATA_W-1:0] rdata,
   // receiver reset pulses
   input wire logic [hdlc_map_pkg::NUM_FRAMERS*hdlc_map_pkg::NUM_LINKS-1:0] rx_link_reset
);
   import hdlc_map_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // both write halves taken at one edge
   sequence s_wr_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   // read address taken
   sequence s_rd_taken;
      arvalid && arready;
   endsequence
   a_write_answer: assert property (s_wr_taken |-> ##2 bvalid)
      else $error("write response late");
   a_bvalid_hold: assert property (bvalid && !bready |=> bvalid)
      else $error("write response dropped");
   a_ready_return: assert property (bvalid && bready |=> awready && wready)
      else $error("write ready not back");
   a_aw_refused: assert property (awvalid && awready |=> !awready)
      else $error("second write address taken");
   a_read_answer: assert property (s_rd_taken |=> rvalid)
      else $error("read answer late");
   a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data changed");
   a_ar_refused: assert property (rvalid |-> !arready)
      else $error("read address taken early");
   a_rdata_upper: assert property (rvalid |-> rdata[31:8] == 24'h0)
      else $error("upper read data set");
   a_reset_pulse: assert property (rx_link_reset != 12'h0 |=> rx_link_reset == 12'h0)
      else $error("receiver reset too long");
endmodule

bind hdlc_link_map hdlc_link_map_props u_props (.mclk(mclk), .rst(rst), .awvalid(awvalid),
   .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
   .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
   .rx_link_reset(rx_link_reset));

// ===== tb/test_hdlc_link_map.sv
// register bank testbench: bus tasks, event and slot map sequences
module test_hdlc_link_map;
   timeunit 1ns;
   timeprecision 1ps;
   import hdlc_map_pkg::*;
   logic mclk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [11:0] awaddr = 0, araddr = 0, bit_pos = 0;
   logic [31:0] wdata = 0, rdata, rd;
   logic [3:0] wstrb = 0, code_declared = 0, esf_or_dm = 0, frame_odd = 0, code_avc_mode;
   logic [2:0] awprot = 0, arprot = 0;
   logic [23:0] code_value = 0, address_match_mode;
   logic [19:0] chan_index = 0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp, resp;
   logic [11:0] tx_link_on, rx_link_on, status_unit_filter, fill_unit_filter;
   logic [11:0] rx_protocol_select, rx_link_reset;
   logic [7:0] tx_insert, rx_extract;
   int n_errors = 0, num_checks = 0, pulses = 0;
   logic [7:0] ofs [16] = '{OFS_CODE_CTRL, OFS_CODE_FLAG, OFS_CODE_VALUE, OFS_TX_EN,
      OFS_TX2_ASSIGN, OFS_TX3_ASSIGN, OFS_TX2_MASK, OFS_TX3_MASK, OFS_RX_EN, OFS_RX2_ASSIGN,
      OFS_RX3_ASSIGN, OFS_RX2_MASK, OFS_RX3_MASK, OFS_RX1_CTRL, OFS_RX2_CTRL, OFS_RX3_CTRL};
   // readback after writing all ones
   logic [7:0] ones [16] = '{8'h03, 8'h00, 8'h3f, 8'h07, 8'h7f, 8'h7f, 8'hff, 8'hff, 8'h07,
      8'h7f, 8'h7f, 8'hff, 8'hff, 8'h3f, 8'h3f, 8'h3f};

   hdlc_link_map dut (.mclk, .rst, .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready,
      .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot, .rvalid,
      .rready, .rdata, .rresp, .code_declared, .code_value, .esf_or_dm, .frame_odd, .chan_index,
      .bit_pos, .tx_link_on, .rx_link_on, .status_unit_filter, .fill_unit_filter,
      .address_match_mode, .rx_protocol_select, .rx_link_reset, .tx_insert, .rx_extract,
      .code_avc_mode, .irq);

   initial begin
      forever #5 mclk = ~mclk;
   end
   // count link one pulses of framer 3
   always @(posedge mclk) if (rx_link_reset[9]) pulses <= pulses + 1;

   // compare and count
   task chk(input string what, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", what, e, g);
         n_errors++;
      end
   endtask
   // axi4-lite write, ready raised late to exercise a stalled response
   task wr(input logic [1:0] f, input logic [7:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      awaddr <= {f, idx, 2'b00};
      wdata <= {24'h0, d};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge mclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (n == 2) bready <= 1'b1;
         n++;
      end while (!(bvalid && bready));
      resp = bresp;
      bready <= 1'b0;
   endtask
   // axi4-lite read
   task rdr(input logic [1:0] f, input logic [7:0] idx);
      int n;
      n = 0;
      araddr <= {f, idx, 2'b00};
      arvalid <= 1'b1;
      do begin
         @(posedge mclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (n == 1) rready <= 1'b1;
         n++;
      end while (!(rvalid && rready));
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   task summarize;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      summarize();
   end

   initial begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      repeat (2) @(posedge mclk);
      foreach (ofs[i]) begin
         rdr(2'h0, ofs[i]);
         chk("reset value", (i == 2) ? RST_CODE_VALUE : RST_ZERO, rd);
         wr(2'h2, ofs[i], 8'hff);
         rdr(2'h2, ofs[i]);
         chk("written value", ones[i], rd);
      end
      rdr(2'h1, OFS_TX2_MASK);
      chk("other framer", 32'h0, rd);
      wr(2'h0, 8'h85, 8'hff);
      chk("unmapped write", RESP_SLVERR, resp);
      rdr(2'h0, 8'h85);
      chk("unmapped read", 32'h0, rd);
      chk("unmapped rresp", RESP_SLVERR, resp);
      // code event on framer 1, enable off then on
      code_value[11:6] <= 6'h2a;
      code_declared[1] <= 1'b1;
      @(posedge mclk);
      code_declared[1] <= 1'b0;
      @(posedge mclk);
      rdr(2'h1, OFS_CODE_VALUE);
      chk("code field", 32'h2a, rd);
      rdr(2'h1, OFS_CODE_FLAG);
      chk("code flag", 32'h1, rd);
      chk("irq masked", 32'h0, irq);
      wr(2'h1, OFS_CODE_CTRL, 8'h03);
      repeat (2) @(posedge mclk);
      chk("irq enabled", 32'h1, irq);
      chk("validation mode", 32'h1, code_avc_mode[1]);
      wr(2'h1, OFS_CODE_FLAG, 8'h01);
      repeat (2) @(posedge mclk);
      rdr(2'h1, OFS_CODE_FLAG);
      chk("flag cleared", 32'h0, rd);
      chk("irq cleared", 32'h0, irq);
      // link enables, link one waits for esf or dm
      wr(2'h0, OFS_TX_EN, 8'h07);
      wr(2'h0, OFS_RX_EN, 8'h07);
      repeat (2) @(posedge mclk);
      chk("enables plain", 6'h36, {tx_link_on[2:0], rx_link_on[2:0]});
      esf_or_dm[0] <= 1'b1;
      repeat (2) @(posedge mclk);
      chk("enables esf", 6'h3f, {tx_link_on[2:0], rx_link_on[2:0]});
      // link 2: transmit even frames bit 7 only, receive odd frames bits 7 and 0, channel 24
      wr(2'h0, OFS_TX2_ASSIGN, 8'h57);
      wr(2'h0, OFS_TX2_MASK, 8'h80);
      wr(2'h0, OFS_RX2_ASSIGN, 8'h37);
      wr(2'h0, OFS_RX2_MASK, 8'h81);
      for (int k = 0; k < 32; k++) begin
         frame_odd[0] <= k[4];
         chan_index[4:0] <= k[3] ? 5'h17 : 5'h16;
         bit_pos[2:0] <= k[2:0];
         repeat (2) @(posedge mclk);
         chk("insert", !k[4] && k[3] && k[2:0] == 7, tx_insert[0]);
         chk("extract", k[4] && k[3] && (k[2:0] == 7 || k[2:0] == 0),
            rx_extract[0]);
      end
      // no frame select on receive, transmit link 2 off
      wr(2'h0, OFS_RX2_ASSIGN, 8'h17);
      wr(2'h0, OFS_TX_EN, 8'h05);
      frame_odd[0] <= 1'b0;
      repeat (2) @(posedge mclk);
      chk("selects off", 32'h0, {rx_extract[0], tx_insert[0], tx_link_on[1]});
      // receiver control fields, framer 3 link 1
      for (int m = 0; m < 4; m++) begin
         wr(2'h3, OFS_RX1_CTRL, {2'b00, m[0], m[1], m[1:0], m[0], 1'b0});
         chk("status filter", m[0], status_unit_filter[9]);
         chk("fill filter", m[1], fill_unit_filter[9]);
         chk("address mode", m[1:0], address_match_mode[19:18]);
         chk("protocol", m[0], rx_protocol_select[9]);
      end
      wr(2'h3, OFS_RX1_CTRL, 8'h01);
      wr(2'h3, OFS_RX1_CTRL, 8'h01);
      chk("one reset pulse", 32'h1, pulses);
      wr(2'h3, OFS_RX1_CTRL, 8'h00);
      wr(2'h3, OFS_RX1_CTRL, 8'h01);
      repeat (2) @(posedge mclk);
      chk("second reset pulse", 32'h2, pulses);
      summarize();
   end
endmodule
